/* File: nssc_pkg.sv */
// nssc_pkg: constants, register map and types of the node strap and status control block
// assumes a single 25 MHz system clock and a synchronous active-high reset
package nssc_pkg;

    // clock and blink timing
    localparam int unsigned CLK_HZ            = 25_000_000;
    localparam int unsigned BLINK_HALF_MS     = 500;
    localparam int unsigned BLINK_HALF_CYCLES = CLK_HZ / 1000 * BLINK_HALF_MS;
    localparam int          BLINK_CNT_W       = 24;

    // widths
    localparam int ADDR_W    = 8;
    localparam int DATA_W    = 32;
    localparam int CAN_ERR_W = 4;

    // register byte addresses
    localparam logic [ADDR_W-1:0] REG_CTRL    = 8'h00;
    localparam logic [ADDR_W-1:0] REG_CONFIG  = 8'h04;
    localparam logic [ADDR_W-1:0] REG_STATUS  = 8'h08;
    localparam logic [ADDR_W-1:0] REG_MASK    = 8'h0c;
    localparam logic [ADDR_W-1:0] REG_PAYLOAD = 8'h10;
    localparam logic [ADDR_W-1:0] REG_FLAGS   = 8'h14;

    // control register fields and reset value
    localparam int                CTRL_LOAD_BIT = 0;
    localparam int                CTRL_RUN_BIT  = 1;
    localparam int                CTRL_W        = 2;
    localparam logic [CTRL_W-1:0] CTRL_RESET    = 2'h2;

    // configuration register fields
    localparam int CFG_ROLE_BIT    = 0;
    localparam int CFG_PAYLOAD_BIT = 1;
    localparam int CFG_RATE_LSB    = 2;
    localparam int CFG_BOOT_LSB    = 4;
    localparam int CFG_FLASH_BIT   = 6;
    localparam int CFG_VALID_BIT   = 7;

    // event bits of status and mask
    localparam int             EV_ERR    = 0;
    localparam int             EV_BUSOFF = 1;
    localparam int             EV_CONFIG = 2;
    localparam int             EV_W      = 3;
    localparam logic [EV_W-1:0] MASK_RESET = 3'h0;

    // frame data patterns
    localparam logic [DATA_W-1:0] PAYLOAD_ALT  = 32'h5555_5555;
    localparam logic [DATA_W-1:0] PAYLOAD_ZERO = 32'h0000_0000;

    // bit rate selection, high strap then low strap
    typedef enum logic [1:0] {
        NSSC_RATE_125K  = 2'b00,
        NSSC_RATE_250K  = 2'b01,
        NSSC_RATE_500K  = 2'b10,
        NSSC_RATE_1000K = 2'b11
    } nssc_rate_t;

    // boot source selection, high strap then low strap
    typedef enum logic [1:0] {
        NSSC_BOOT_PARALLEL = 2'b00,
        NSSC_BOOT_SERIAL   = 2'b01,
        NSSC_BOOT_WAIT     = 2'b10,
        NSSC_BOOT_DEFAULT  = 2'b11
    } nssc_boot_t;

    // startup sequence
    typedef enum logic [1:0] {
        NSSC_ST_HOLD   = 2'b00,
        NSSC_ST_SAMPLE = 2'b01,
        NSSC_ST_RUN    = 2'b10
    } nssc_state_t;

endpackage

/* File: nssc_blink_timer.sv */
// nssc_blink_timer: shared half-period timer giving one blink phase for all indicators
// assumes ref_clk at CLK_HZ and a synchronous reset
module nssc_blink_timer import nssc_pkg::*; #(
    parameter int unsigned HALF_CYCLES = BLINK_HALF_CYCLES
) (
    input  wire logic ref_clk,
    input  wire logic sys_rst,
    input  wire logic clk_en,
    output logic      phase
);

    logic [BLINK_CNT_W-1:0] count;
    logic                   wrap;

    assign wrap = (count == BLINK_CNT_W'(HALF_CYCLES - 1));

    // count cycles, restart at the end of each half period
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            count <= '0;
        end else if (clk_en) begin
            count <= wrap ? '0 : count + 1'b1;
        end
    end

    // toggle the phase every half period, 50 percent duty
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            phase <= 1'b0;
        end else if (clk_en && wrap) begin
            phase <= ~phase; // R14
        end
    end

endmodule

/* File: nssc_strap_sampler.sv */
// nssc_strap_sampler: waits for the processor reset release, then latches the straps once
// assumes strap levels are synchronous to ref_clk and stable around the release
module nssc_strap_sampler import nssc_pkg::*; (
    input  wire logic ref_clk,
    input  wire logic sys_rst,
    input  wire logic clk_en,
    input  wire logic cpu_reset_n,
    input  wire logic role_strap,
    input  wire logic payload_strap,
    input  wire logic rate_strap_high,
    input  wire logic rate_strap_low,
    input  wire logic boot_strap_high,
    input  wire logic boot_strap_low,
    output logic      cfg_valid,
    output logic      cfg_done,
    output logic      node_is_master,
    output logic      payload_high,
    output nssc_rate_t bit_rate,
    output nssc_boot_t boot_source
);

    nssc_state_t state;

    // hold while the supervisor keeps the processor in reset, sample once, then run
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state <= NSSC_ST_HOLD;
        end else if (clk_en) begin
            case (state)
                NSSC_ST_HOLD:   state <= cpu_reset_n ? NSSC_ST_SAMPLE : NSSC_ST_HOLD; // R7
                NSSC_ST_SAMPLE: state <= NSSC_ST_RUN;
                NSSC_ST_RUN:    state <= NSSC_ST_RUN; // R15
                default:        state <= NSSC_ST_HOLD;
            endcase
        end
    end

    // latch the strap levels in the single sample cycle
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            node_is_master <= 1'b0;
            payload_high   <= 1'b0;
            bit_rate       <= NSSC_RATE_125K;
            boot_source    <= NSSC_BOOT_PARALLEL;
        end else if (clk_en && state == NSSC_ST_SAMPLE) begin
            node_is_master <= role_strap; // R1
            payload_high   <= payload_strap; // R2
            bit_rate       <= nssc_rate_t'({rate_strap_high, rate_strap_low}); // R4
            boot_source    <= nssc_boot_t'({boot_strap_high, boot_strap_low}); // R5
        end
    end

    // valid level and one-cycle done pulse
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            cfg_valid <= 1'b0;
            cfg_done  <= 1'b0;
        end else if (clk_en) begin
            cfg_valid <= (state == NSSC_ST_SAMPLE) || cfg_valid; // R15
            cfg_done  <= (state == NSSC_ST_SAMPLE);
        end
    end

endmodule

/* File: nssc_node_ctrl.sv */
// nssc_node_ctrl: strap configuration, status indicators, test load switch and register port
// assumes one 25 MHz clock, synchronous active-high reset, a simple strobe register port
//
// Function
// R1: a high role strap at startup makes the node the bus master, a low one makes it a slave.
// R2: a low payload strap at startup selects the pattern 55555555 hex for every frame's data field.
// R3: a high payload strap at startup selects an all-zero data field for every frame.
// R4: the rate straps, high then low, select 125, 250, 500 or 1000 kbps in binary order.
// R5: the boot straps, high then low, select parallel load, serial load, wait or default boot.
// R6: with both boot straps high the default boot runs from on-chip flash, not from a port.
// R7: the supervisor holds the processor reset low until the supply is good; startup waits for it.
// R8: the blue indicator blinks at 1 Hz while any controller error flag is set, else it is off.
// R9: the green indicator blinks at 1 Hz while bus-off is reported, else it is off.
// R10: the red indicator blinks at 1 Hz as a heartbeat while the node runs normally.
// R11: the yellow indicator blinks at 1 Hz only when the node is configured as master.
// R12: the load-enable output connects the 500 mA test load when high and removes it when low.
// R13: while the load-enable output is not driven the load stays disconnected.
// R14: every blink has 50 percent duty, toggling each 500 ms, with one shared phase.
// R15: the straps are sampled once after reset; later changes are ignored until the next reset.
// R16: the remote node must use the same bit rate, and exactly one node is the master.
module nssc_node_ctrl import nssc_pkg::*; #(
    parameter int unsigned HALF_PERIOD_CYCLES = BLINK_HALF_CYCLES
) (
    input  wire logic                 ref_clk,
    input  wire logic                 sys_rst,
    input  wire logic                 clk_en,
    // supervisor reset and straps
    input  wire logic                 cpu_reset_n,
    input  wire logic                 role_strap,
    input  wire logic                 payload_strap,
    input  wire logic                 rate_strap_high,
    input  wire logic                 rate_strap_low,
    input  wire logic                 boot_strap_high,
    input  wire logic                 boot_strap_low,
    // controller status flags
    input  wire logic [CAN_ERR_W-1:0] can_err_flags,
    input  wire logic                 can_bus_off,
    // register port
    input  wire logic [ADDR_W-1:0]    reg_addr,
    input  wire logic [DATA_W-1:0]    reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output logic      [DATA_W-1:0]    reg_rdata,
    output logic                      irq,
    // configuration results
    output logic                      cfg_valid,
    output logic                      node_is_master,
    output logic      [DATA_W-1:0]    frame_payload,
    output nssc_rate_t                bit_rate,
    output nssc_boot_t                boot_source,
    output logic                      boot_from_flash,
    // indicators and load switch
    output logic                      led_blue,
    output logic                      led_green,
    output logic                      led_red,
    output logic                      led_yellow,
    output logic                      test_load_enable_o,
    output logic                      test_load_enable_oe
);

    logic              cfg_done;
    logic              payload_high;
    logic              phase;
    logic [CTRL_W-1:0] ctrl;
    logic [EV_W-1:0]   status;
    logic [EV_W-1:0]   mask;
    logic [EV_W-1:0]   event_in;
    logic              any_err;
    logic              any_err_q;
    logic              bus_off_q;
    logic              running;
    logic              wr_ctrl;
    logic              wr_status;
    logic              wr_mask;
    logic [DATA_W-1:0] next_rdata;
    logic [DATA_W-1:0] config_word;

    // one-time strap capture after the processor reset is released
    nssc_strap_sampler u_sampler (
        .ref_clk         (ref_clk),
        .sys_rst         (sys_rst),
        .clk_en          (clk_en),
        .cpu_reset_n     (cpu_reset_n),
        .role_strap      (role_strap),
        .payload_strap   (payload_strap),
        .rate_strap_high (rate_strap_high),
        .rate_strap_low  (rate_strap_low),
        .boot_strap_high (boot_strap_high),
        .boot_strap_low  (boot_strap_low),
        .cfg_valid       (cfg_valid),
        .cfg_done        (cfg_done),
        .node_is_master  (node_is_master),
        .payload_high    (payload_high),
        .bit_rate        (bit_rate),
        .boot_source     (boot_source)
    );

    // shared blink phase for every indicator
    nssc_blink_timer #(
        .HALF_CYCLES (HALF_PERIOD_CYCLES)
    ) u_blink (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .clk_en  (clk_en),
        .phase   (phase)
    );

    // frame data field and flash boot flag follow the latched straps
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            frame_payload   <= PAYLOAD_ALT;
            boot_from_flash <= 1'b0;
        end else if (clk_en) begin
            frame_payload   <= payload_high ? PAYLOAD_ZERO : PAYLOAD_ALT; // R2 R3
            boot_from_flash <= cfg_valid && (boot_source == NSSC_BOOT_DEFAULT); // R6
        end
    end

    // status flag summary
    assign any_err = |can_err_flags;
    assign running = cfg_valid && ctrl[CTRL_RUN_BIT];

    // indicators: gated by their condition, all on the shared phase
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            led_blue   <= 1'b0;
            led_green  <= 1'b0;
            led_red    <= 1'b0;
            led_yellow <= 1'b0;
        end else if (clk_en) begin
            led_blue   <= any_err && phase; // R8 R14
            led_green  <= can_bus_off && phase; // R9 R14
            led_red    <= running && phase; // R10 R14
            led_yellow <= cfg_valid && node_is_master && phase; // R11 R14
        end
    end

    // load switch: not driven until configured, so the gate pull-down keeps it off
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            test_load_enable_o  <= 1'b0;
            test_load_enable_oe <= 1'b0; // R13
        end else if (clk_en) begin
            test_load_enable_o  <= cfg_valid && ctrl[CTRL_LOAD_BIT]; // R12
            test_load_enable_oe <= cfg_valid; // R13
        end
    end

    // register write decode
    assign wr_ctrl   = reg_wr && (reg_addr == REG_CTRL);
    assign wr_status = reg_wr && (reg_addr == REG_STATUS);
    assign wr_mask   = reg_wr && (reg_addr == REG_MASK);

    // control register: load request and heartbeat run bit
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            ctrl <= CTRL_RESET;
        end else if (clk_en && wr_ctrl) begin
            ctrl <= reg_wdata[CTRL_W-1:0];
        end
    end

    // interrupt mask
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            mask <= MASK_RESET;
        end else if (clk_en && wr_mask) begin
            mask <= reg_wdata[EV_W-1:0];
        end
    end

    // edge history for event detection
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            any_err_q <= 1'b0;
            bus_off_q <= 1'b0;
        end else if (clk_en) begin
            any_err_q <= any_err;
            bus_off_q <= can_bus_off;
        end
    end

    // event pulses: error rise, bus-off rise, configuration done
    assign event_in[EV_ERR]    = any_err && !any_err_q;
    assign event_in[EV_BUSOFF] = can_bus_off && !bus_off_q;
    assign event_in[EV_CONFIG] = cfg_done;

    // sticky status bits, write one to clear, a new event beats the clear
    for (genvar i = 0; i < EV_W; i++) begin : g_status
        always_ff @(posedge ref_clk) begin
            if (sys_rst) begin
                status[i] <= 1'b0;
            end else if (clk_en) begin
                if (event_in[i]) begin
                    status[i] <= 1'b1;
                end else if (wr_status && reg_wdata[i]) begin
                    status[i] <= 1'b0;
                end
            end
        end
    end

    // level interrupt while any unmasked status bit is set
    assign irq = |(status & mask);

    // configuration word as seen by software
    always_comb begin
        config_word                                 = '0;
        config_word[CFG_ROLE_BIT]                   = node_is_master;
        config_word[CFG_PAYLOAD_BIT]                = payload_high;
        config_word[CFG_RATE_LSB +: 2]              = bit_rate;
        config_word[CFG_BOOT_LSB +: 2]              = boot_source;
        config_word[CFG_FLASH_BIT]                  = boot_from_flash;
        config_word[CFG_VALID_BIT]                  = cfg_valid;
    end

    // read mux, unmapped addresses read zero
    always_comb begin
        next_rdata = '0;
        case (reg_addr)
            REG_CTRL:    next_rdata[CTRL_W-1:0] = ctrl;
            REG_CONFIG:  next_rdata = config_word;
            REG_STATUS:  next_rdata[EV_W-1:0] = status;
            REG_MASK:    next_rdata[EV_W-1:0] = mask;
            REG_PAYLOAD: next_rdata = frame_payload;
            REG_FLAGS:   next_rdata[CAN_ERR_W:0] = {can_bus_off, can_err_flags};
            default:     next_rdata = '0;
        endcase
    end

    // read data stands only in the cycle after the read strobe
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            reg_rdata <= '0;
        end else if (clk_en) begin
            reg_rdata <= reg_rd ? next_rdata : '0;
        end
    end

endmodule

/* File: nssc_node_monitor.sv */
// nssc_node_monitor: port-level checks of the node strap and status control block
// assumes binding to nssc_node_ctrl; blink stretches are counted in enabled cycles only
module nssc_node_monitor import nssc_pkg::*; #(
    parameter int unsigned HALF_PERIOD_CYCLES = BLINK_HALF_CYCLES
) (
    input wire logic                 ref_clk,
    input wire logic                 sys_rst,
    input wire logic                 clk_en,
    input wire logic                 role_strap,
    input wire logic                 payload_strap,
    input wire logic                 rate_strap_high,
    input wire logic                 rate_strap_low,
    input wire logic                 boot_strap_high,
    input wire logic                 boot_strap_low,
    input wire logic [CAN_ERR_W-1:0] can_err_flags,
    input wire logic                 can_bus_off,
    input wire logic [ADDR_W-1:0]    reg_addr,
    input wire logic [DATA_W-1:0]    reg_wdata,
    input wire logic                 reg_wr,
    input wire logic                 cfg_valid,
    input wire logic                 node_is_master,
    input wire logic [DATA_W-1:0]    frame_payload,
    input wire nssc_rate_t           bit_rate,
    input wire nssc_boot_t           boot_source,
    input wire logic                 boot_from_flash,
    input wire logic                 led_blue,
    input wire logic                 led_green,
    input wire logic                 led_red,
    input wire logic                 led_yellow,
    input wire logic                 test_load_enable_o,
    input wire logic                 test_load_enable_oe
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    logic [31:0] red_hi;
    // length of the current lit stretch of the heartbeat
    always_ff @(posedge ref_clk) begin
        if (sys_rst || !led_red)
            red_hi <= '0;
        else if (clk_en)
            red_hi <= red_hi + 32'h1;
    end
    sequence cfg_rise_s;
        $rose(cfg_valid);
    endsequence
    sequence ctrl_wr_s;
        reg_wr && reg_addr == REG_CTRL && cfg_valid;
    endsequence
    role_latch_a: assert property (cfg_rise_s |-> node_is_master == $past(role_strap))
        else $error("role not taken from strap");
    payload_pick_a: assert property (cfg_rise_s |=> frame_payload == ($past(payload_strap, 2) ? PAYLOAD_ZERO : PAYLOAD_ALT))
        else $error("wrong frame data pattern");
    rate_pick_a: assert property (cfg_rise_s |-> bit_rate == {$past(rate_strap_high), $past(rate_strap_low)})
        else $error("wrong bit rate");
    boot_pick_a: assert property (cfg_rise_s |-> boot_source == {$past(boot_strap_high), $past(boot_strap_low)})
        else $error("wrong boot source");
    flash_boot_a: assert property (cfg_rise_s |=> boot_from_flash == (boot_source == NSSC_BOOT_DEFAULT))
        else $error("flash boot flag wrong");
    cfg_frozen_a: assert property (cfg_valid && $past(cfg_valid) |-> $stable(node_is_master) && $stable(bit_rate) && $stable(boot_source))
        else $error("configuration changed after sampling");
    blue_cause_a: assert property (led_blue |-> $past(|can_err_flags))
        else $error("blue lit without error flag");
    green_cause_a: assert property (led_green |-> $past(can_bus_off))
        else $error("green lit without bus off");
    yellow_master_a: assert property (led_yellow |-> node_is_master && led_red)
        else $error("yellow lit out of phase or as slave");
    red_half_a: assert property ($fell(led_red) |-> red_hi == HALF_PERIOD_CYCLES)
        else $error("heartbeat half period wrong");
    load_follow_a: assert property (ctrl_wr_s |-> ##2 test_load_enable_o == $past(reg_wdata[CTRL_LOAD_BIT], 2))
        else $error("load enable did not follow request");
    load_idle_a: assert property (!test_load_enable_oe |-> !test_load_enable_o)
        else $error("load driven while pin released");
endmodule

bind nssc_node_ctrl nssc_node_monitor #(.HALF_PERIOD_CYCLES(HALF_PERIOD_CYCLES)) u_mon (.*);

/* File: nssc_far_model.sv */
// nssc_far_model: strap switches, reset supervisor and controller flags around the node block
// assumes the bench sets switch levels and controller conditions
module nssc_far_model #(
    parameter int RAIL_CYCLES = 2
) (
    input  wire logic       ref_clk,
    input  wire logic       sys_rst,
    input  wire logic [5:0] switches,
    input  wire logic [4:0] ctrl_cond,
    output logic            cpu_reset_n,
    output logic            role_strap,
    output logic            payload_strap,
    output logic            rate_strap_high,
    output logic            rate_strap_low,
    output logic            boot_strap_high,
    output logic            boot_strap_low,
    output logic [3:0]      can_err_flags,
    output logic            can_bus_off
);
    int hold;
    // supervisor keeps the processor reset low until the rail settles
    always_ff @(posedge ref_clk) begin
        if (sys_rst)
            hold <= RAIL_CYCLES;
        else if (hold != 0)
            hold <= hold - 1;
    end
    assign cpu_reset_n = (hold == 0);
    // switches pull each strap firmly high or low
    assign {role_strap, payload_strap, rate_strap_high, rate_strap_low, boot_strap_high, boot_strap_low} = switches;
    // controller flags as seen with a peer at matching rate and role
    assign {can_bus_off, can_err_flags} = ctrl_cond;
endmodule

/* File: tb.sv */
// tb: self-checking bench for nssc_node_ctrl with the far-side model
// assumes a short blink half period so blink timing fits in the run
module tb import nssc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HALF = 8;
    logic ref_clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, clk_en = 1'b1;
    logic [7:0] reg_addr = '0;
    logic [31:0] reg_wdata = '0, rdat, reg_rdata, frame_payload;
    logic [5:0] switches = '0;
    logic [4:0] ctrl_cond = '0;
    logic cpu_reset_n, role_strap, payload_strap, rate_strap_high, rate_strap_low, boot_strap_high, boot_strap_low;
    logic [3:0] can_err_flags;
    logic can_bus_off, irq, cfg_valid, node_is_master, boot_from_flash;
    logic led_blue, led_green, led_red, led_yellow, test_load_enable_o, test_load_enable_oe;
    nssc_rate_t bit_rate;
    nssc_boot_t boot_source;
    int fail_count = 0, checks_done = 0, seed = 27, cyc = 0, n[4];
    nssc_node_ctrl #(.HALF_PERIOD_CYCLES(HALF)) u_dut (.clk_en(clk_en), .*);
    nssc_far_model u_far (.*);
    // clock and hang limit
    initial forever #20 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 5000) begin
            fail_count++;
            wrap_up();
        end
    end
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // waits whole cycles, then lets the edge's updates land
    task automatic cycles(input int k);
        repeat (k) @(posedge ref_clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        cycles(1);
        reg_wr <= 1'b0;
        cycles(1);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        reg_addr <= a;
        reg_rd <= 1'b1;
        cycles(1);
        reg_rd <= 1'b0;
        d = reg_rdata;
        cycles(1);
    endtask
    // expected configuration word from switch levels
    function automatic logic [31:0] exp_cfg(input logic [5:0] s);
        return {24'h0, 1'b1, s[1:0] == 2'b11, s[1:0], s[3:2], s[4], s[5]};
    endfunction
    task automatic boot_node(input logic [5:0] s);
        switches <= s;
        sys_rst <= 1'b1;
        cycles(6);
        chk(test_load_enable_oe, 1'b0);
        sys_rst <= 1'b0;
        cycles(12);
    endtask
    // counts lit cycles of each indicator over one full blink period
    task automatic lights(input logic [4:0] c, input logic m);
        ctrl_cond <= c;
        cycles(4);
        n = '{default: 0};
        repeat (2 * HALF) begin
            cycles(1);
            n[0] += led_blue;
            n[1] += led_green;
            n[2] += led_red;
            n[3] += led_yellow;
        end
        chk(n[0], (|c[3:0]) ? HALF : 0);
        chk(n[1], c[4] ? HALF : 0);
        chk(n[2], HALF);
        chk(n[3], m ? HALF : 0);
    endtask
    // strap combinations, indicators, load switch and interrupt
    initial begin
        logic [5:0] s;
        logic [31:0] rv;
        for (int i = 0; i < 16; i++) begin
            rv = $random(seed);
            s = (i == 15) ? 6'h3f : {rv[1:0], i[3:0]};
            boot_node(s);
            chk(node_is_master, s[5]);
            chk(frame_payload, s[4] ? PAYLOAD_ZERO : PAYLOAD_ALT);
            chk(bit_rate, s[3:2]);
            chk(boot_source, s[1:0]);
            chk(boot_from_flash, s[1:0] == 2'b11);
            rd(REG_CONFIG, rdat);
            chk(rdat, exp_cfg(s));
            switches <= ~s;
            cycles(4);
            rd(REG_CONFIG, rdat);
            chk(rdat, exp_cfg(s));
            lights(rv[6:2], s[5]);
            rd(REG_PAYLOAD, rdat);
            chk(rdat, s[4] ? PAYLOAD_ZERO : PAYLOAD_ALT);
            rd(REG_FLAGS, rdat);
            chk(rdat, {27'h0, rv[6:2]});
        end
        wr(REG_CTRL, 32'h3);
        cycles(2);
        chk(test_load_enable_o, 1'b1);
        chk(test_load_enable_oe, 1'b1);
        wr(REG_CTRL, 32'h2);
        cycles(2);
        chk(test_load_enable_o, 1'b0);
        ctrl_cond <= 5'h0;
        cycles(2);
        wr(REG_STATUS, 32'h7);
        rd(REG_STATUS, rdat);
        chk(rdat, 32'h0);
        wr(REG_MASK, 32'h1);
        ctrl_cond <= 5'h01;
        cycles(3);
        chk(irq, 1'b1);
        wr(REG_MASK, 32'h0);
        cycles(1);
        chk(irq, 1'b0);
        wr(REG_MASK, 32'h1);
        wr(REG_STATUS, 32'h1);
        cycles(1);
        chk(irq, 1'b0);
        rd(8'h3c, rdat);
        chk(rdat, 32'h0);
        // a low clock enable must freeze the heartbeat for a whole half period
        rv[0] = led_red;
        clk_en <= 1'b0;
        cycles(HALF);
        chk(led_red, rv[0]);
        clk_en <= 1'b1;
        cycles(2);
        wrap_up();
    end
endmodule
